/* rtl/psm_defines.vh */
// Purpose: constants for the power save mode controller
// Assumes: 125 MHz mclk_i, APB register access, word-aligned offsets
// Notes:   included by psm_ctrl.v and psm_clkgate.v
//
// What this block does
// - after reset run on system rc, undivided; fll and plls off
// - after reset the core boots from flash address 0x00000000
// - analog supply por always active; it resets the entire chip
// - a wake event returns to the run state held before entry
// - a reset during power save always returns to default run state
// - i/o line configuration is held unchanged in every save mode
// - sleep depth 0..3 stops cpu, ahb, apb/generic, then fast sources
// - depth gating overrides the ahb and apb clock mask registers
// - in light sleep only clocked modules may wake the system
// - enter light sleep on wait-for-interrupt, or on isr exit if flagged
// - leave light sleep on an unmasked interrupt of enough priority
// - wait and retention keep the core domain powered and retained
// - wait and retention stop all clocks but enabled 32 kHz sources
// - backup mode powers off the core domain, keeps backup domain
// - wait and retention wake only on enabled asynchronous sources
`ifndef PSM_DEFINES_VH
`define PSM_DEFINES_VH

// register byte offsets
`define PSM_OFF_CTRL      12'h000
`define PSM_OFF_AHBMASK   12'h004
`define PSM_OFF_APBMASK   12'h008
`define PSM_OFF_STATUS    12'h00C
`define PSM_OFF_RUNSTATE  12'h010
`define PSM_OFF_BOOT      12'h014

// control register fields
`define PSM_CTRL_DEPTH_LSB 0
`define PSM_CTRL_DEPTH_MSB 1
`define PSM_CTRL_RET_BIT   2
`define PSM_CTRL_BKUP_BIT  3
`define PSM_CTRL_OSC32_BIT 4
`define PSM_CTRL_RC32_BIT  5

// reset values
`define PSM_CTRL_RST      6'h00
`define PSM_MASK_RST      32'hFFFFFFFF
`define PSM_RUN_DEFAULT   2'h0
`define PSM_BOOT_ADDR     32'h00000000

// mode codes
`define PSM_M_RUN         3'h0
`define PSM_M_SLEEP       3'h1
`define PSM_M_WAIT        3'h2
`define PSM_M_RET         3'h3
`define PSM_M_BKUP        3'h4

// sleep depth codes
`define PSM_D_CPU         2'h0
`define PSM_D_AHB         2'h1
`define PSM_D_APB         2'h2
`define PSM_D_SRC         2'h3

// core domain power-up settle time in ns, and its cycle count
`define PSM_CLK_NS        8
`define PSM_SETTLE_NS     200
`define PSM_SETTLE_CYC    ((`PSM_SETTLE_NS + `PSM_CLK_NS - 1) / `PSM_CLK_NS)

`endif

/* rtl/psm_clkgate.v */
// Purpose: clock-enable decode for each sleep depth and deep mode
// Assumes: enables are levels consumed by glitch-free gates outside
// Notes:   masks from software are anded after the mode decode
`timescale 1ns/1ps
`default_nettype none
`include "psm_defines.vh"

module psm_clkgate (
    input  wire [2:0]  mode_i,      // current power mode
    input  wire [1:0]  depth_i,     // latched sleep depth
    input  wire [31:0] ahb_mask_i,  // per-module ahb clock mask
    input  wire [31:0] apb_mask_i,  // per-module apb clock mask
    input  wire        osc32_en_i,  // 32k crystal enabled beforehand
    input  wire        rc32_en_i,   // 32k rc enabled beforehand
    output wire        cpu_clk_en_o, // cpu clock running
    output wire [31:0] ahb_en_o,    // ahb module clocks
    output wire [31:0] apb_en_o,    // apb module clocks
    output wire        generic_clocks_en_o, // generic clocks
    output wire        fast_src_en_o, // main osc, fast rc, 80m rc, pll, fll
    output wire        sysrc_en_o,  // system rc oscillator
    output wire        osc32_o,     // 32k crystal running
    output wire        rc32_o       // 32k rc running
);
    wire deep;
    wire slp;
    wire bus_run;
    wire apb_run;

    assign deep = (mode_i == `PSM_M_WAIT) || (mode_i == `PSM_M_RET) ||
                  (mode_i == `PSM_M_BKUP);
    assign slp  = (mode_i == `PSM_M_SLEEP);

    // depth thresholds; deep modes stop everything but 32k
    assign cpu_clk_en_o  = (mode_i == `PSM_M_RUN);
    assign bus_run       = !deep && !(slp && depth_i >= `PSM_D_AHB);
    assign apb_run       = !deep && !(slp && depth_i >= `PSM_D_APB);
    assign generic_clocks_en_o = apb_run;
    assign fast_src_en_o = !deep && !(slp && depth_i == `PSM_D_SRC);
    assign sysrc_en_o    = !deep;

    // gating wins over the masks: a set mask bit cannot revive it
    assign ahb_en_o = ahb_mask_i & {32{bus_run}};
    assign apb_en_o = apb_mask_i & {32{apb_run}};

    // 32k sources keep running only if enabled before entry
    assign osc32_o = osc32_en_i;
    assign rc32_o  = rc32_en_i;
endmodule
`default_nettype wire

/* rtl/psm_ctrl.v */
// Purpose: power save mode controller with apb register access
// Assumes: core signals are synchronous pulses/levels on mclk_i
// Notes:   the analog por input resets everything, regardless of mode
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "psm_defines.vh"

module psm_ctrl (
    input  wire        mclk_i,        // system clock
    input  wire        nrst_i,        // synchronous reset, active low
    input  wire        analog_supply_por_n_i, // low while supply below por
    input  wire        ext_reset_n_i, // other reset sources, active low
    // apb slave
    input  wire        psel_i,        // apb select
    input  wire        penable_i,     // apb enable
    input  wire        pwrite_i,      // apb direction
    input  wire [11:0] paddr_i,       // apb byte address
    input  wire [31:0] pwdata_i,      // apb write data
    output wire        pready_o,      // apb ready
    output wire        pslverr_o,     // apb error for unmapped address
    output reg  [31:0] prdata_o,      // apb read data
    // core side
    input  wire        wait_for_interrupt_instr_i, // sleep instruction pulse
    input  wire        isr_exit_i,    // exit from lowest priority isr
    input  wire        sleep_after_isr_i, // sleep-after-isr flag
    input  wire        deep_sleep_i,  // deep-sleep select
    input  wire        irq_wake_i,    // unmasked irq able to enter exception
    input  wire        async_wake_i,  // enabled asynchronous wake source
    input  wire        bkup_wake_i,   // enabled backup-domain wake source
    input  wire [1:0]  run_state_i,   // run state set by software
    input  wire        run_state_we_i, // strobe for run_state_i
    // outputs
    output reg  [1:0]  run_state_o,   // current run state
    output reg  [2:0]  mode_o,        // current power mode
    output reg         core_pwr_en_o, // core domain supply on
    output reg         core_rst_n_o,  // core domain reset, active low
    output reg         io_hold_o,     // freeze i/o line configuration
    output reg  [31:0] boot_addr_o,   // vector fetch address for the core
    output reg         freq_locked_loop_en_o, // fll enable
    output reg         pll_en_o,      // pll enable
    output reg  [3:0]  sysclk_div_o,  // system clock divider, 0 = undivided
    output wire        cpu_clk_en_o,  // cpu clock enable
    output wire [31:0] ahb_en_o,      // ahb module clock enables
    output wire [31:0] apb_en_o,      // apb module clock enables
    output wire        generic_clocks_en_o, // generic clock enable
    output wire        fast_src_en_o, // fast clock sources enable
    output wire        sysrc_en_o,    // system rc oscillator enable
    output wire        osc32_o,       // 32k crystal run
    output wire        rc32_o         // 32k rc run
);
    localparam S_RUN   = 3'h0;
    localparam S_SLEEP = 3'h1;
    localparam S_WAIT  = 3'h2;
    localparam S_RET   = 3'h3;
    localparam S_BKUP  = 3'h4;
    localparam S_PWRUP = 3'h5;

    // the count is worked out as an integer; keep only the counter's bits
    localparam integer SETTLE_FULL = `PSM_SETTLE_CYC;
    localparam [7:0]   SETTLE      = SETTLE_FULL[7:0];

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [5:0]  ctrl;
    reg  [31:0] ahb_mask;
    reg  [31:0] apb_mask;
    reg  [1:0]  saved_run;
    reg  [1:0]  depth_lat;
    reg  [7:0]  settle_cnt;
    reg         bkup_flag;
    wire        any_rst;
    wire        sleep_req;
    wire        wr;
    wire        rd;

    // choose one mode from the select bits; backup wins
    function [2:0] pick_mode;
        input deep;
        input ret;
        input bkup;
        begin
            if (deep && bkup)
                pick_mode = S_BKUP;
            else if (deep && ret)
                pick_mode = S_RET;
            else if (deep)
                pick_mode = S_WAIT;
            else
                pick_mode = S_SLEEP;
        end
    endfunction

    // register decode used only by the pslverr_o error path
    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `PSM_OFF_CTRL) || (a == `PSM_OFF_AHBMASK) ||
                     (a == `PSM_OFF_APBMASK) || (a == `PSM_OFF_STATUS) ||
                     (a == `PSM_OFF_RUNSTATE) || (a == `PSM_OFF_BOOT);
        end
    endfunction

    // por is never gated by the mode: it always forces full reset
    assign any_rst = !nrst_i || !analog_supply_por_n_i || !ext_reset_n_i;

    // sleep instruction or flagged isr exit starts a save mode
    assign sleep_req = wait_for_interrupt_instr_i ||
                       (isr_exit_i && sleep_after_isr_i);

    // apb: zero wait states, error only on unmapped addresses
    assign wr        = psel_i && penable_i && pwrite_i;
    assign rd        = psel_i && !penable_i && !pwrite_i;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped(paddr_i);

    // next-state logic
    always @* begin
        next_state = state;
        case (state)
            S_RUN: begin
                if (sleep_req)
                    next_state = pick_mode(deep_sleep_i,
                                           ctrl[`PSM_CTRL_RET_BIT],
                                           ctrl[`PSM_CTRL_BKUP_BIT]);
            end
            // only clocked sources reach irq_wake_i in sleep
            S_SLEEP: begin
                if (irq_wake_i)
                    next_state = S_RUN;
            end
            // synchronous irqs are dead here; async sources only
            S_WAIT, S_RET: begin
                if (async_wake_i)
                    next_state = S_RUN;
            end
            S_BKUP: begin
                if (bkup_wake_i)
                    next_state = S_PWRUP;
            end
            S_PWRUP: begin
                if (settle_cnt == 8'h00)
                    next_state = S_RUN;
            end
            default: next_state = S_RUN;
        endcase
    end

    // mode state, run state and power sequencing
    always @(posedge mclk_i) begin
        if (any_rst) begin
            state        <= S_RUN;
            run_state_o  <= `PSM_RUN_DEFAULT;
            saved_run    <= `PSM_RUN_DEFAULT;
            depth_lat    <= `PSM_D_CPU;
            settle_cnt   <= 8'h00;
            bkup_flag    <= 1'b0;
        end else begin
            state <= next_state;
            if (state == S_RUN && next_state != S_RUN) begin
                saved_run <= run_state_o;
                depth_lat <= ctrl[`PSM_CTRL_DEPTH_MSB:`PSM_CTRL_DEPTH_LSB];
            end
            if (next_state == S_PWRUP && state == S_BKUP) begin
                settle_cnt <= SETTLE - 8'h01;
                bkup_flag  <= 1'b1;
            end else if (settle_cnt != 8'h00) begin
                settle_cnt <= settle_cnt - 8'h01;
            end
            // a wake restores the run state held at entry
            if (state != S_RUN && next_state == S_RUN)
                run_state_o <= saved_run;
            else if (state == S_RUN && run_state_we_i)
                run_state_o <= run_state_i;
        end
    end

    // registered power, reset and clock-source outputs
    always @(posedge mclk_i) begin
        if (any_rst) begin
            mode_o                <= `PSM_M_RUN;
            core_pwr_en_o         <= 1'b1;
            core_rst_n_o          <= 1'b0;
            io_hold_o             <= 1'b0;
            boot_addr_o           <= `PSM_BOOT_ADDR;
            freq_locked_loop_en_o <= 1'b0;
            pll_en_o              <= 1'b0;
            sysclk_div_o          <= 4'h0;
        end else begin
            mode_o <= next_state == S_PWRUP ? `PSM_M_BKUP : next_state;
            // core domain stays powered in wait and retention
            core_pwr_en_o <= (next_state != S_BKUP);
            // core held in reset until supply settles after backup
            core_rst_n_o  <= (next_state == S_RUN) ||
                             (core_rst_n_o && next_state != S_PWRUP);
            // i/o config frozen while any save mode is active
            io_hold_o     <= (next_state != S_RUN);
            boot_addr_o   <= `PSM_BOOT_ADDR;
        end
    end

    // apb register writes
    always @(posedge mclk_i) begin
        if (any_rst) begin
            ctrl     <= `PSM_CTRL_RST;
            ahb_mask <= `PSM_MASK_RST;
            apb_mask <= `PSM_MASK_RST;
        end else if (wr) begin
            case (paddr_i)
                `PSM_OFF_CTRL:    ctrl     <= pwdata_i[5:0];
                `PSM_OFF_AHBMASK: ahb_mask <= pwdata_i;
                `PSM_OFF_APBMASK: apb_mask <= pwdata_i;
                default:          ctrl     <= ctrl;
            endcase
        end
    end

    // apb read data, captured in the setup cycle
    always @(posedge mclk_i) begin
        if (any_rst) begin
            prdata_o <= 32'h00000000;
        end else if (rd) begin
            case (paddr_i)
                `PSM_OFF_CTRL:     prdata_o <= {26'h0, ctrl};
                `PSM_OFF_AHBMASK:  prdata_o <= ahb_mask;
                `PSM_OFF_APBMASK:  prdata_o <= apb_mask;
                `PSM_OFF_STATUS:   prdata_o <= {27'h0, bkup_flag, 1'b0, state};
                `PSM_OFF_RUNSTATE: prdata_o <= {30'h0, run_state_o};
                `PSM_OFF_BOOT:     prdata_o <= boot_addr_o;
                default:           prdata_o <= 32'h00000000;
            endcase
        end
    end

    // clock gating decode for the current mode
    psm_clkgate u_gate (
        .mode_i        (mode_o),
        .depth_i       (depth_lat),
        .ahb_mask_i    (ahb_mask),
        .apb_mask_i    (apb_mask),
        .osc32_en_i    (ctrl[`PSM_CTRL_OSC32_BIT]),
        .rc32_en_i     (ctrl[`PSM_CTRL_RC32_BIT]),
        .cpu_clk_en_o  (cpu_clk_en_o),
        .ahb_en_o      (ahb_en_o),
        .apb_en_o      (apb_en_o),
        .generic_clocks_en_o (generic_clocks_en_o),
        .fast_src_en_o (fast_src_en_o),
        .sysrc_en_o    (sysrc_en_o),
        .osc32_o       (osc32_o),
        .rc32_o        (rc32_o)
    );
endmodule
`default_nettype wire

/* testbench/psm_ctrl_monitor.sv */
// Purpose: port-level checks on the power save mode controller
// Assumes: single mclk_i domain, synchronous active-low resets
// Notes:   por and other resets are folded into live for antecedents
`timescale 1ns/1ps
`default_nettype none
module psm_ctrl_monitor (
    input wire logic        mclk_i,                // system clock
    input wire logic        nrst_i,                // sync reset
    input wire logic        analog_supply_por_n_i, // supply por
    input wire logic        ext_reset_n_i,         // other resets
    input wire logic        wait_for_interrupt_instr_i, // sleep pulse
    input wire logic        deep_sleep_i,          // deep select
    input wire logic        irq_wake_i,            // irq wake
    input wire logic        async_wake_i,          // async wake
    input wire logic [1:0]  run_state_o,           // run state
    input wire logic [2:0]  mode_o,                // power mode
    input wire logic        core_pwr_en_o,         // core supply
    input wire logic        core_rst_n_o,          // core reset
    input wire logic        io_hold_o,             // i/o freeze
    input wire logic [31:0] boot_addr_o,           // vector address
    input wire logic        freq_locked_loop_en_o, // fll enable
    input wire logic        pll_en_o,              // pll enable
    input wire logic [3:0]  sysclk_div_o,          // divider
    input wire logic        cpu_clk_en_o,          // cpu clock
    input wire logic        fast_src_en_o,         // fast sources
    input wire logic        sysrc_en_o             // system rc
);
    // a low por or other reset restarts everything, so guard on it
    wire logic live;
    assign live = analog_supply_por_n_i & ext_reset_n_i;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // light sleep request taken in run
    sequence light_req;
        live && mode_o == 3'h0 && wait_for_interrupt_instr_i
            && !deep_sleep_i;
    endsequence
    // resting in wait or retention
    sequence deep_hold;
        live && (mode_o == 3'h2 || mode_o == 3'h3);
    endsequence
    run_clks_a:
        assert property (mode_o == 3'h0 |-> sysrc_en_o && !pll_en_o
            && !freq_locked_loop_en_o && sysclk_div_o == 4'h0)
        else $error("run clocking wrong");
    boot_vec_a:
        assert property (boot_addr_o == 32'h00000000)
        else $error("boot address wrong");
    reset_run_a:
        assert property (!live |=> mode_o == 3'h0 && run_state_o == 2'h0
            && !core_rst_n_o) else $error("reset left save mode wrong");
    light_entry_a:
        assert property (light_req ##1 live |-> mode_o == 3'h1)
        else $error("light sleep not entered");
    hold_io_a:
        assert property (mode_o != 3'h0 |-> io_hold_o)
        else $error("i/o not held");
    sleep_cpu_a:
        assert property (mode_o == 3'h1 |-> !cpu_clk_en_o && sysrc_en_o)
        else $error("light sleep clocks wrong");
    deep_clk_a:
        assert property (deep_hold |-> !cpu_clk_en_o && !fast_src_en_o
            && !sysrc_en_o) else $error("deep mode clocks running");
    keep_core_a:
        assert property (deep_hold |-> core_pwr_en_o && core_rst_n_o)
        else $error("core domain lost");
    light_wake_a:
        assert property (live && mode_o == 3'h1 && irq_wake_i
            |-> ##[1:2] mode_o == 3'h0) else $error("no light wake");
    deep_wake_a:
        assert property (deep_hold and irq_wake_i && !async_wake_i
            |=> $stable(mode_o)) else $error("sync wake left deep mode");
endmodule
bind psm_ctrl psm_ctrl_monitor psm_ctrl_monitor_i (
    .mclk_i, .nrst_i, .analog_supply_por_n_i, .ext_reset_n_i,
    .wait_for_interrupt_instr_i,
    .deep_sleep_i, .irq_wake_i, .async_wake_i, .run_state_o, .mode_o,
    .core_pwr_en_o, .core_rst_n_o, .io_hold_o, .boot_addr_o,
    .freq_locked_loop_en_o, .pll_en_o, .sysclk_div_o, .cpu_clk_en_o,
    .fast_src_en_o, .sysrc_en_o
);
`default_nettype wire

/* testbench/psm_core_model.sv */
// Purpose: processor core side that requests the power save modes
// Assumes: selects settle one cycle before the sleep instruction
// Notes:   driven only through sleep_req, never kinder than a core
`timescale 1ns/1ps
`default_nettype none
module psm_core_model (
    input  wire logic mclk_i,            // system clock
    output logic      wait_for_interrupt_instr_o, // sleep pulse
    output logic      isr_exit_o,        // lowest priority isr return
    output logic      sleep_after_isr_o, // sleep-after-isr flag
    output logic      deep_sleep_o       // deep-sleep select
);
    // idle core; no partial wake request exists here
    initial begin
        wait_for_interrupt_instr_o = 1'b0;
        isr_exit_o = 1'b0;
        sleep_after_isr_o = 1'b0;
        deep_sleep_o = 1'b0;
    end
    // select first, then a one-cycle sleep pulse
    task automatic sleep_req(input logic deep, input logic via_isr);
        @(posedge mclk_i);
        deep_sleep_o <= deep;
        sleep_after_isr_o <= via_isr;
        @(posedge mclk_i);
        wait_for_interrupt_instr_o <= !via_isr;
        isr_exit_o <= via_isr;
        @(posedge mclk_i);
        wait_for_interrupt_instr_o <= 1'b0;
        isr_exit_o <= 1'b0;
        sleep_after_isr_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* testbench/psm_ctrl_tb.sv */
// Purpose: self-checking bench for the power save mode controller
// Assumes: zero-wait apb slave, core pins from psm_core_model
// Notes:   every wait is bounded and ends in wrap_up on expiry
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("Error %s expected %0h seen %0h", nm, exp, got); \
    end \
end
module psm_ctrl_tb;
    logic        mclk_i, nrst_i, analog_supply_por_n_i, ext_reset_n_i;
    logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, boot_addr_o, ahb_en_o, apb_en_o, rd;
    logic        wait_for_interrupt_instr_i, isr_exit_i, sleep_after_isr_i;
    logic        deep_sleep_i, err;
    logic        irq_wake_i, async_wake_i, bkup_wake_i, run_state_we_i;
    logic [1:0]  run_state_i, run_state_o;
    logic [2:0]  mode_o;
    logic        core_pwr_en_o, core_rst_n_o, io_hold_o, pll_en_o;
    logic        freq_locked_loop_en_o, cpu_clk_en_o, generic_clocks_en_o;
    logic        fast_src_en_o, sysrc_en_o, osc32_o, rc32_o;
    logic [3:0]  sysclk_div_o;
    int          miscompares, n_compared;
    psm_ctrl psm_ctrl_i (
        .mclk_i, .nrst_i, .analog_supply_por_n_i, .ext_reset_n_i,
        .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
        .pslverr_o, .prdata_o, .wait_for_interrupt_instr_i, .isr_exit_i,
        .sleep_after_isr_i,
        .deep_sleep_i, .irq_wake_i, .async_wake_i, .bkup_wake_i,
        .run_state_i, .run_state_we_i, .run_state_o, .mode_o,
        .core_pwr_en_o, .core_rst_n_o, .io_hold_o, .boot_addr_o,
        .freq_locked_loop_en_o, .pll_en_o, .sysclk_div_o, .cpu_clk_en_o,
        .ahb_en_o, .apb_en_o, .generic_clocks_en_o, .fast_src_en_o,
        .sysrc_en_o,
        .osc32_o, .rc32_o
    );
    psm_core_model psm_core_model_i (
        .mclk_i(mclk_i),
        .wait_for_interrupt_instr_o(wait_for_interrupt_instr_i),
        .isr_exit_o(isr_exit_i),
        .sleep_after_isr_o(sleep_after_isr_i), .deep_sleep_o(deep_sleep_i)
    );
    always #4 mclk_i = ~mclk_i;
    // single exit of the run
    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one apb transfer; request held until pready seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge mclk_i);
            if (pready_o === 1'b1) break;
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (k == 16) begin
            miscompares++;
            wrap_up();
        end
    endtask
    // sampled at falling edges so clocked updates have landed
    task automatic wait_mode(input logic [2:0] m);
        int k;
        for (k = 0; k < 64; k++) begin
            @(negedge mclk_i);
            if (mode_o === m) break;
        end
        if (k == 64) begin
            miscompares++;
            wrap_up();
        end
    endtask
    // one-cycle wake or reset event: 0 irq 1 async 2 backup 3 ext 4 por
    task automatic pulse(input int s);
        @(posedge mclk_i);
        irq_wake_i <= (s == 0);
        async_wake_i <= (s == 1);
        bkup_wake_i <= (s == 2);
        ext_reset_n_i <= (s != 3);
        analog_supply_por_n_i <= (s != 4);
        @(posedge mclk_i);
        {irq_wake_i, async_wake_i, bkup_wake_i} <= 3'h0;
        {ext_reset_n_i, analog_supply_por_n_i} <= 2'h3;
    endtask
    task automatic set_run(input logic [1:0] rs);
        @(posedge mclk_i);
        run_state_i <= rs;
        run_state_we_i <= 1'b1;
        @(posedge mclk_i);
        run_state_we_i <= 1'b0;
    endtask
    task automatic t_after_reset();
        `CHK("mode", 3'h0, mode_o)
        `CHK("cpu clk", 1'b1, cpu_clk_en_o)
        `CHK("sysrc", 1'b1, sysrc_en_o)
        `CHK("fll", 1'b0, freq_locked_loop_en_o)
        `CHK("pll", 1'b0, pll_en_o)
        `CHK("div", 4'h0, sysclk_div_o)
        `CHK("boot", 32'h00000000, boot_addr_o)
        apb(1'b0, 12'h004, 32'h0);
        `CHK("ahb mask", 32'hFFFFFFFF, rd)
        apb(1'b0, 12'h018, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        $display("after reset test done");
    endtask
    task automatic t_light();
        int i;
        logic [1:0] d;
        set_run(2'h2);
        apb(1'b1, 12'h004, 32'h0000FFFF);
        for (i = 0; i < 4; i++) begin
            d = i[1:0];
            apb(1'b1, 12'h000, {30'h0, d});
            psm_core_model_i.sleep_req(1'b0, d == 2'h3);
            wait_mode(3'h1);
            `CHK("cpu clk", 1'b0, cpu_clk_en_o)
            `CHK("ahb", d == 0 ? 32'h0000FFFF : 32'h0, ahb_en_o)
            `CHK("apb", d < 2, apb_en_o[0])
            `CHK("gen clk", d < 2, generic_clocks_en_o)
            `CHK("fast src", d != 3, fast_src_en_o)
            `CHK("io hold", 1'b1, io_hold_o)
            pulse(0);
            wait_mode(3'h0);
            `CHK("run state", 2'h2, run_state_o)
        end
        $display("light sleep test done");
    endtask
    task automatic t_deep();
        int r;
        set_run(2'h1);
        for (r = 0; r < 2; r++) begin
            apb(1'b1, 12'h000, r ? 32'h00000024 : 32'h00000010);
            psm_core_model_i.sleep_req(1'b1, 1'b0);
            wait_mode(r ? 3'h3 : 3'h2);
            `CHK("core pwr", 1'b1, core_pwr_en_o)
            `CHK("32k", r ? 2'h1 : 2'h2, {osc32_o, rc32_o})
            pulse(0);
            repeat (2) @(negedge mclk_i);
            `CHK("mode", r ? 3'h3 : 3'h2, mode_o)
            // a run state write while asleep must be refused
            set_run(2'h3);
            @(negedge mclk_i);
            `CHK("run held", 2'h1, run_state_o)
            pulse(1);
            wait_mode(3'h0);
            `CHK("run state", 2'h1, run_state_o)
        end
        $display("wait retention test done");
    endtask
    task automatic t_backup();
        set_run(2'h3);
        apb(1'b1, 12'h000, 32'h0000000C);
        psm_core_model_i.sleep_req(1'b1, 1'b0);
        wait_mode(3'h4);
        `CHK("core pwr", 1'b0, core_pwr_en_o)
        pulse(2);
        wait_mode(3'h0);
        `CHK("core rst", 1'b1, core_rst_n_o)
        `CHK("run state", 2'h3, run_state_o)
        apb(1'b0, 12'h00C, 32'h0);
        `CHK("status", 32'h00000010, rd)
        $display("backup test done");
    endtask
    task automatic t_reset_save();
        int s;
        for (s = 3; s < 5; s++) begin
            set_run(2'h2);
            apb(1'b1, 12'h000, 32'h0);
            psm_core_model_i.sleep_req(1'b1, 1'b0);
            wait_mode(3'h2);
            pulse(s);
            wait_mode(3'h0);
            `CHK("run state", 2'h0, run_state_o)
        end
        $display("reset in save mode test done");
    endtask
    initial begin
        mclk_i = 1'b0;
        nrst_i = 1'b0;
        {analog_supply_por_n_i, ext_reset_n_i} = 2'h3;
        {psel_i, penable_i, pwrite_i} = 3'h0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        {irq_wake_i, async_wake_i, bkup_wake_i, run_state_we_i} = 4'h0;
        run_state_i = 2'h0;
        miscompares = 0;
        n_compared = 0;
        repeat (8) @(posedge mclk_i);
        nrst_i <= 1'b1;
        repeat (2) @(negedge mclk_i);
        t_after_reset();
        t_light();
        t_deep();
        t_backup();
        t_reset_save();
        wrap_up();
    end
endmodule
`default_nettype wire
